// ===== rtl/pwdt_pkg.sv
// Package with register map, field layout and timing for the watchdog
package pwdt_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [3:0] ADDR_CONFIG = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_MASK = 4'h2;
	localparam logic [3:0] ADDR_COUNT = 4'h3;

	// ==========================================================
	// Config field positions
	localparam int CFG_EN_BIT = 0;
	localparam int CFG_CLR_BIT = 1;
	localparam int CFG_PER_LO = 2;
	localparam int CFG_MODE_BIT = 4;
	localparam int CFG_LOCK_BIT = 7;

	// Status field positions
	localparam int ST_RST_BIT = 0;
	localparam int ST_OFF_BIT = 1;

	// ==========================================================
	// Reset values
	localparam logic [1:0] PER_RESET = 2'h3;
	localparam logic MODE_RESET = 1'b0;
	localparam logic [1:0] FLAG_RESET = 2'h0;
	localparam logic [1:0] MASK_RESET = 2'h0;

	// ==========================================================
	// Timing
	localparam longint CLK_HZ = 125000000;
	localparam int TICK_HZ = 1;
	localparam longint TICK_CYCLES_L = CLK_HZ / TICK_HZ;
	localparam int SHORT_TIMEOUT_S = 16;
	localparam int LONG_TIMEOUT_S = 128;
	localparam int TICK_W = 27;
	localparam int SEC_W = 8;

	// ==========================================================
	// Types
	typedef enum logic [1:0]
	{
		PWDT_IDLE = 2'b00,
		PWDT_RUN = 2'b01,
		PWDT_FIRE = 2'b10
	} pwdt_state_e;

	typedef struct packed
	{
		logic enable;
		logic [1:0] period;
		logic mode;
	} pwdt_cfg_s;

	typedef struct packed
	{
		logic reset_req;
		logic off_req;
	} pwdt_req_s;

endpackage : pwdt_pkg

// ===== rtl/pwdt_regs.sv
// Interrupt status register with write-one-to-clear, and a plain read/write mask register
`timescale 1ns/1ps
module pwdt_regs
	import pwdt_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [1:0] events,
	input wire logic status_wr,
	input wire logic mask_wr,
	input wire logic [1:0] wdata,
	output logic [1:0] status_reg,
	output logic [1:0] mask_reg,
	output logic irq
);

	// ==========================================================
	// Sticky status, set wins over clear
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			status_reg <= FLAG_RESET;
		else if (status_wr)
			status_reg <= (status_reg & ~wdata) | events;
		else
			status_reg <= status_reg | events;
	end

	// ==========================================================
	// Mask
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			mask_reg <= MASK_RESET;
		else if (mask_wr)
			mask_reg <= wdata;
	end

	assign irq = |(status_reg & mask_reg);

endmodule : pwdt_regs

// ===== rtl/pwdt_tick.sv
// Slow timebase divider producing a one-cycle tick enable
`timescale 1ns/1ps
module pwdt_tick
	import pwdt_pkg::*;
#(
	parameter logic [TICK_W-1:0] TICK_DIV = TICK_W'(TICK_CYCLES_L)
)
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic restart,
	output logic tick
);

	logic [TICK_W-1:0] div_reg;

	// ==========================================================
	// Divider
	always_ff @(posedge mclk)
	begin
		if (!resetn || restart)
			div_reg <= '0;
		else if (div_reg == TICK_DIV - TICK_W'(1))
			div_reg <= '0;
		else
			div_reg <= div_reg + TICK_W'(1);
	end

	assign tick = resetn && !restart && (div_reg == TICK_DIV - TICK_W'(1));

endmodule : pwdt_tick

// ===== rtl/pwdt_top.sv
// Watchdog timer core with register port and expiry requests
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps

// How it works
// R1 - On expiry, request shutdown and return configuration to defaults.
// R2 - Counting runs only while enable is one; disabled never expires.
// R3 - Two-bit period field selects four timeouts from 16 s to 128 s.
// R4 - Period field resets to the 128 s setting.
// R5 - Host clears before timeout; each clear restarts count from zero.
// R6 - Lock bit is read-only and fixed at manufacture.
// R7 - Lock 0, default 0: reset disabled, writes enable and disable.
// R8 - Lock 0, default 1: reset enabled, writes disable and re-enable.
// R9 - Lock 1, default 0: enable accepted, disable ignored, reset only clears. Expiry also clears enable, since it restores EN_OTP.
// R10 - Lock 1, default 1: enabled from reset, nothing disables it.
// R11 - Mode 1 at expiry sets reset flag and requests cold reset.
// R12 - Mode 0 at expiry sets off flag and requests power-off.
// R13 - Period codes 0..3 give 16, 32, 64, 128 s on slow tick.
// R14 - Clear bit self-clears and always reads back zero.
module pwdt_top
	import pwdt_pkg::*;
#(
	parameter logic LOCK_OTP = 1'b0,
	parameter logic EN_OTP = 1'b0,
	parameter logic [TICK_W-1:0] TICK_DIV = TICK_W'(TICK_CYCLES_L)
)
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [7:0] rdata,
	output pwdt_req_s expiry_req,
	output logic irq
);

	pwdt_cfg_s cfg_reg;
	pwdt_state_e state_reg;
	logic [SEC_W-1:0] sec_reg;
	logic [SEC_W-1:0] limit;
	logic tick;
	logic clear_hit;
	logic expire;
	logic cfg_wr;
	logic [1:0] status_q;
	logic [1:0] mask_q;
	logic [1:0] events;
	logic en_wr_val;

	// ==========================================================
	// Register decode
	assign cfg_wr = wr_stb && (addr == ADDR_CONFIG);
	assign clear_hit = cfg_wr && wdata[CFG_CLR_BIT]; // [R5] [R14]
	assign en_wr_val = wdata[CFG_EN_BIT];

	// ==========================================================
	// Timeout limit per period code
	always_comb
	begin
		case (cfg_reg.period) // [R3] [R13]
			2'h0: limit = SEC_W'(SHORT_TIMEOUT_S);
			2'h1: limit = SEC_W'(SHORT_TIMEOUT_S * 2);
			2'h2: limit = SEC_W'(SHORT_TIMEOUT_S * 4);
			default: limit = SEC_W'(LONG_TIMEOUT_S);
		endcase
	end

	// ==========================================================
	// Timebase
	pwdt_tick #(
		.TICK_DIV(TICK_DIV)
	) u_tick (
		.mclk(mclk),
		.resetn(resetn),
		.restart(clear_hit || state_reg != PWDT_RUN),
		.tick(tick)
	);

	assign expire = (state_reg == PWDT_RUN) && tick &&
		(sec_reg == limit - SEC_W'(1));

	// ==========================================================
	// Configuration register
	always_ff @(posedge mclk)
	begin
		if (!resetn || state_reg == PWDT_FIRE)
		begin
			cfg_reg.enable <= EN_OTP; // [R1] [R7] [R8] [R10]
			cfg_reg.period <= PER_RESET; // [R4]
			cfg_reg.mode <= MODE_RESET;
		end
		else if (cfg_wr)
		begin
			cfg_reg.period <= wdata[CFG_PER_LO +: 2];
			cfg_reg.mode <= wdata[CFG_MODE_BIT];
			if (!LOCK_OTP)
				cfg_reg.enable <= en_wr_val; // [R7] [R8]
			else if (en_wr_val)
				cfg_reg.enable <= 1'b1; // [R9] [R10]
		end
	end

	// ==========================================================
	// Watchdog state machine
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			state_reg <= PWDT_IDLE;
		else
		begin
			case (state_reg)
				PWDT_IDLE:
					if (cfg_reg.enable)
						state_reg <= PWDT_RUN; // [R2]
				PWDT_RUN:
					if (!cfg_reg.enable)
						state_reg <= PWDT_IDLE; // [R2]
					else if (expire && !clear_hit)
						state_reg <= PWDT_FIRE; // [R1]
				PWDT_FIRE:
					state_reg <= PWDT_IDLE;
				default:
					state_reg <= PWDT_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Seconds counter
	always_ff @(posedge mclk)
	begin
		if (!resetn || clear_hit || state_reg != PWDT_RUN)
			sec_reg <= '0; // [R5]
		else if (tick)
			sec_reg <= sec_reg + SEC_W'(1);
	end

	// ==========================================================
	// Expiry requests
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			expiry_req <= '0;
		else
		begin
			expiry_req.reset_req <= expire && !clear_hit &&
				cfg_reg.enable && cfg_reg.mode; // [R11]
			expiry_req.off_req <= expire && !clear_hit &&
				cfg_reg.enable && !cfg_reg.mode; // [R12]
		end
	end

	assign events[ST_RST_BIT] = expiry_req.reset_req; // [R11]
	assign events[ST_OFF_BIT] = expiry_req.off_req; // [R12]

	// ==========================================================
	// Status and interrupt
	pwdt_regs u_regs (
		.mclk(mclk),
		.resetn(resetn),
		.events(events),
		.status_wr(wr_stb && addr == ADDR_STATUS),
		.mask_wr(wr_stb && addr == ADDR_MASK),
		.wdata(wdata[1:0]),
		.status_reg(status_q),
		.mask_reg(mask_q),
		.irq(irq)
	);

	// ==========================================================
	// Read data
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			rdata <= 8'h00;
		else if (rd_stb)
		begin
			case (addr)
				ADDR_CONFIG:
					rdata <= {LOCK_OTP, 2'h0, cfg_reg.mode,
						cfg_reg.period, 1'b0, cfg_reg.enable}; // [R6] [R14]
				ADDR_STATUS:
					rdata <= {6'h00, status_q};
				ADDR_MASK:
					rdata <= {6'h00, mask_q};
				ADDR_COUNT:
					rdata <= sec_reg;
				default:
					rdata <= 8'h00;
			endcase
		end
		else
			rdata <= 8'h00;
	end

	// ==========================================================
	// Checks
	AST_DISABLED_NO_EXPIRY: assert property (@(posedge mclk) disable iff (!resetn)
		!cfg_reg.enable |=> !expiry_req.reset_req && !expiry_req.off_req) // [R2]
		else $error("expiry while disabled");

	AST_PERIOD_RESET: assert property (@(posedge mclk)
		$rose(resetn) |-> cfg_reg.period == 2'h3) // [R4]
		else $error("period not at longest after reset");

	AST_CLEAR_RESTARTS: assert property (@(posedge mclk) disable iff (!resetn)
		clear_hit |=> sec_reg == '0) // [R5]
		else $error("clear did not restart count");

	AST_DEFAULTS_ON_EXPIRY: assert property (@(posedge mclk)
		disable iff (!resetn)
		state_reg == PWDT_FIRE |=> cfg_reg.period == PER_RESET &&
		cfg_reg.enable == EN_OTP) // [R1]
		else $error("config not restored after expiry");

	AST_LOCK_HOLDS: assert property (@(posedge mclk) disable iff (!resetn)
		LOCK_OTP && cfg_reg.enable && state_reg != PWDT_FIRE |=>
		cfg_reg.enable) // [R9]
		else $error("locked enable cleared");

	AST_UNLOCKED_DISABLE: assert property (@(posedge mclk)
		disable iff (!resetn)
		!LOCK_OTP && cfg_wr && !en_wr_val |=> !cfg_reg.enable) // [R7]
		else $error("unlocked disable write ignored");

	AST_RESET_REQ: assert property (@(posedge mclk) disable iff (!resetn)
		expiry_req.reset_req |=> status_q[ST_RST_BIT]) // [R11]
		else $error("reset flag not set");

	AST_OFF_REQ: assert property (@(posedge mclk) disable iff (!resetn)
		expiry_req.off_req |=> status_q[ST_OFF_BIT] &&
		state_reg == PWDT_IDLE) // [R12]
		else $error("off flag not set");

	AST_CLEAR_READS_ZERO: assert property (@(posedge mclk)
		disable iff (!resetn)
		rd_stb && addr == ADDR_CONFIG |=> !rdata[CFG_CLR_BIT]) // [R14]
		else $error("clear bit read back one");

	AST_EXPIRY_TIME: assert property (@(posedge mclk) disable iff (!resetn)
		expire |-> sec_reg == limit - SEC_W'(1)) // [R3]
		else $error("expiry at wrong second");

	COV_EXPIRE_RESET: cover property (@(posedge mclk) expiry_req.reset_req);
	COV_EXPIRE_OFF: cover property (@(posedge mclk) expiry_req.off_req);
	COV_CLEAR_RUN: cover property (@(posedge mclk)
		clear_hit && state_reg == PWDT_RUN);
	COV_IRQ: cover property (@(posedge mclk) irq);

endmodule : pwdt_top

// ===== verif/pwdt_host.sv
// Host model driving the watchdog register port
`timescale 1ns/1ps
module pwdt_host
(
	input wire logic mclk,
	input wire logic [31:0] rdata_all,
	output logic [3:0] addr,
	output logic [7:0] wdata,
	output logic wr_stb,
	output logic rd_stb
);
	// ==========================================================
	// Idle bus
	initial
	begin
		addr = 4'h0;
		wdata = 8'h00;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
	end

	// ==========================================================
	// One-cycle write, used for config, mask and status writes
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
	endtask : wr

	// One-cycle read, data taken in the following cycle
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge mclk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		#1;
		v = rdata_all;
	endtask : rd
endmodule : pwdt_host

// ===== verif/pwdt_tb.sv
// Testbench for the watchdog with all four factory options
`timescale 1ns/1ps
module pmic_watchdog_timer_tb_top
	import pwdt_pkg::*;
;
	localparam int DIV = 4;
	logic mclk;
	logic resetn;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic wr_stb;
	logic rd_stb;
	logic [31:0] rdata_all;
	logic [3:0] rst_req;
	logic [3:0] off_req;
	logic [3:0] irq;
	logic [31:0] v;
	int bad_count;
	int n_checks;
	int pulses;

	// ==========================================================
	// Instances: lock is index bit 1, enable default bit 0
	generate
		for (genvar i = 0; i < 4; i++)
		begin : g
			pwdt_req_s req;
			pwdt_top #(.LOCK_OTP(1'(i / 2)), .EN_OTP(1'(i % 2)),
				.TICK_DIV(TICK_W'(DIV))) dut
			(
				.mclk(mclk),
				.resetn(resetn),
				.addr(addr),
				.wdata(wdata),
				.wr_stb(wr_stb),
				.rd_stb(rd_stb),
				.rdata(rdata_all[8*i +: 8]),
				.expiry_req(req),
				.irq(irq[i])
			);
			assign rst_req[i] = req.reset_req;
			assign off_req[i] = req.off_req;
		end
	endgenerate

	pwdt_host host
	(
		.mclk(mclk),
		.rdata_all(rdata_all),
		.addr(addr),
		.wdata(wdata),
		.wr_stb(wr_stb),
		.rd_stb(rd_stb)
	);

	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	always @(posedge mclk)
		if ((rst_req | off_req) !== 4'h0)
			pulses++;

	// ==========================================================
	// Helpers
	function automatic logic [31:0] cfgx(input logic [3:0] en,
		input logic [2:0] low);
		logic [31:0] r;
		for (int i = 0; i < 4; i++)
			r[8*i +: 8] = {i > 1, 2'h0, low, 1'b0, en[i]};
		return r;
	endfunction : cfgx

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	// Enable, clear and set period, then time the expiry
	task automatic expire(input logic [1:0] code, input logic mode);
		int n;
		int lim;
		lim = (16 << code) * DIV;
		n = 0;
		host.wr(ADDR_CONFIG, {3'h0, mode, code, 2'h1});
		host.wr(ADDR_CONFIG, {3'h0, mode, code, 2'h3});
		while (n < lim + 20 && (rst_req | off_req) === 4'h0)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n >= lim + 20)
		begin
			bad_count++;
			end_sim();
		end
		chk({31'h0, n >= lim - 4 && n <= lim + 6}, 32'h1);
		chk({rst_req, off_req}, mode ? 8'hF0 : 8'h0F);
		host.rd(ADDR_CONFIG, v);
		chk(v, cfgx(4'hA, 3'h3));
		host.rd(ADDR_STATUS, v);
		chk(v, mode ? 32'h01010101 : 32'h02020202);
		chk(irq, 4'h0);
		host.wr(ADDR_MASK, {6'h0, ~mode, mode});
		#1;
		chk(irq, 4'hF);
		host.wr(ADDR_STATUS, 8'h03);
		#1;
		chk(irq, 4'h0);
		host.rd(ADDR_STATUS, v);
		chk(v, 32'h0);
	endtask : expire

	// ==========================================================
	// Main sequence
	initial
	begin
		bad_count = 0;
		n_checks = 0;
		pulses = 0;
		resetn = 1'b0;
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		host.rd(ADDR_CONFIG, v);
		chk(v, cfgx(4'hA, 3'h3));
		host.wr(ADDR_CONFIG, 8'h80);
		host.rd(ADDR_CONFIG, v);
		chk(v, cfgx(4'h8, 3'h0));
		host.wr(ADDR_CONFIG, 8'h01);
		host.rd(ADDR_CONFIG, v);
		chk(v, cfgx(4'hF, 3'h0));
		host.wr(ADDR_CONFIG, 8'h00);
		host.rd(ADDR_CONFIG, v);
		chk(v, cfgx(4'hC, 3'h0));
		repeat (4)
		begin
			repeat (40) @(posedge mclk);
			host.wr(ADDR_CONFIG, 8'h02);
		end
		host.rd(ADDR_CONFIG, v);
		chk(v, cfgx(4'hC, 3'h0));
		chk(pulses, 32'h0);
		for (int c = 0; c < 4; c++)
			expire(2'(c), c[0]);
		host.rd(4'hF, v);
		chk(v, 32'h0);
		end_sim();
	end
endmodule : pmic_watchdog_timer_tb_top
